/* pulse_edge_generator.v */
/*
  Pulse edge generator: register file, edge equations for resonant,
  triangular and leading-edge modes, and the match logic that drives
  the two pulse outputs and the trigger pulses. Assumes filter duty and
  period arrive synchronous to clk and that the filter keeps its own
  period at twice its duty in resonant mode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pulse_edge_consts.vh"
module pulse_edge_generator #(
  parameter WIDTH = 16
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire clkEn,
  // Register port
  input wire [4:0] regAddr,
  input wire [WIDTH-1:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [WIDTH-1:0] regRdata,
  // Compensator filter
  input wire [WIDTH-1:0] filterDuty,
  input wire [WIDTH-1:0] filterPeriod,
  // Pulse outputs
  output wire primary_pulse_out,
  output wire secondary_pulse_out,
  // Trigger pulses, one cycle each
  output reg adaptTrig,
  output reg phaseTrig,
  output reg sampTrig1,
  output reg sampTrig2,
  // Blanking windows
  output wire blankA,
  output wire blankB
);
  reg [4:0] ctrl_reg;
  reg [WIDTH-1:0] period_limit_reg;
  reg [WIDTH-1:0] ev1_reg;
  reg [WIDTH-1:0] ev2_reg;
  reg [WIDTH-1:0] ev3_reg;
  reg [WIDTH-1:0] ev4_reg;
  reg [WIDTH-1:0] adjA_reg;
  reg [WIDTH-1:0] adjB_reg;
  reg [WIDTH-1:0] adapt_reg;
  reg [WIDTH-1:0] phase_reg;
  reg [WIDTH-1:0] samp1_reg;
  reg [WIDTH-1:0] samp2_reg;
  reg [WIDTH-1:0] blkABeg_reg;
  reg [WIDTH-1:0] blkAEnd_reg;
  reg [WIDTH-1:0] blkBBeg_reg;
  reg [WIDTH-1:0] blkBEnd_reg;
  reg [WIDTH-1:0] duty_reg;
  reg [WIDTH-1:0] fperiod_reg;
  reg [1:0] mode_reg;
  reg [WIDTH-1:0] aRise;
  reg [WIDTH-1:0] aFall;
  reg [WIDTH-1:0] bRise;
  reg [WIDTH-1:0] bFall;
  reg [WIDTH-1:0] adaptAt;
  reg aActive;
  reg adaptActive;
  wire [WIDTH-1:0] count;
  wire periodStart;
  wire run;
  wire [WIDTH-1:0] deadTime1;
  wire [WIDTH-1:0] deadTime2;
  wire [WIDTH:0] deadSum;
  wire [WIDTH-1:0] deadAvg;
  wire [WIDTH-1:0] dutyHalf;
  wire [WIDTH-1:0] periodHalf;
  wire [WIDTH-1:0] resOn;
  wire [WIDTH-1:0] leadRise;
  wire [WIDTH-1:0] phaseAt;
  wire blankANext;
  wire blankBNext;
  reg blankA_reg;
  reg blankB_reg;

  assign run = ctrl_reg[`CTRL_ENABLE];

  // Register writes; the mode and filter values latch per period so a
  // change mid-period cannot tear an edge pair.
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg <= 5'h00;
      period_limit_reg <= `PERIOD_RESET;
      ev1_reg <= `EVENT_RESET;
      ev2_reg <= `EVENT_RESET;
      ev3_reg <= `EVENT_RESET;
      ev4_reg <= `EVENT_RESET;
      adjA_reg <= `EVENT_RESET;
      adjB_reg <= `EVENT_RESET;
      adapt_reg <= `EVENT_RESET;
      phase_reg <= `EVENT_RESET;
      samp1_reg <= `EVENT_RESET;
      samp2_reg <= `EVENT_RESET;
      blkABeg_reg <= `EVENT_RESET;
      blkAEnd_reg <= `EVENT_RESET;
      blkBBeg_reg <= `EVENT_RESET;
      blkBEnd_reg <= `EVENT_RESET;
    end
    else if (clkEn && regWr)
    begin
      case (regAddr)
        `ADDR_CTRL: ctrl_reg <= regWdata[4:0];
        `ADDR_PERIOD: period_limit_reg <= regWdata;
        `ADDR_EVENT1: ev1_reg <= regWdata;
        `ADDR_EVENT2: ev2_reg <= regWdata;
        `ADDR_EVENT3: ev3_reg <= regWdata;
        `ADDR_EVENT4: ev4_reg <= regWdata;
        `ADDR_ADJ_A: adjA_reg <= regWdata;
        `ADDR_ADJ_B: adjB_reg <= regWdata;
        `ADDR_ADAPT: adapt_reg <= regWdata;
        `ADDR_PHASE: phase_reg <= regWdata;
        `ADDR_SAMP1: samp1_reg <= regWdata;
        `ADDR_SAMP2: samp2_reg <= regWdata;
        `ADDR_BLKA_BEG: blkABeg_reg <= regWdata;
        `ADDR_BLKA_END: blkAEnd_reg <= regWdata;
        `ADDR_BLKB_BEG: blkBBeg_reg <= regWdata;
        `ADDR_BLKB_END: blkBEnd_reg <= regWdata;
        default: ;
      endcase
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge clk)
  begin
    if (rst)
      regRdata <= {WIDTH{1'b0}};
    else if (clkEn)
    begin
      if (!regRd)
        regRdata <= {WIDTH{1'b0}};
      else
      begin
        case (regAddr)
          `ADDR_CTRL: regRdata <= {{(WIDTH-5){1'b0}}, ctrl_reg};
          `ADDR_PERIOD: regRdata <= period_limit_reg;
          `ADDR_EVENT1: regRdata <= ev1_reg;
          `ADDR_EVENT2: regRdata <= ev2_reg;
          `ADDR_EVENT3: regRdata <= ev3_reg;
          `ADDR_EVENT4: regRdata <= ev4_reg;
          `ADDR_ADJ_A: regRdata <= adjA_reg;
          `ADDR_ADJ_B: regRdata <= adjB_reg;
          `ADDR_ADAPT: regRdata <= adapt_reg;
          `ADDR_PHASE: regRdata <= phase_reg;
          `ADDR_SAMP1: regRdata <= samp1_reg;
          `ADDR_SAMP2: regRdata <= samp2_reg;
          `ADDR_BLKA_BEG: regRdata <= blkABeg_reg;
          `ADDR_BLKA_END: regRdata <= blkAEnd_reg;
          `ADDR_BLKB_BEG: regRdata <= blkBBeg_reg;
          `ADDR_BLKB_END: regRdata <= blkBEnd_reg;
          `ADDR_STATUS: regRdata <= {{(WIDTH-4){1'b0}}, blankB_reg,
            blankA_reg, secondary_pulse_out, primary_pulse_out};
          `ADDR_COUNT: regRdata <= count;
          default: regRdata <= {WIDTH{1'b0}};
        endcase
      end
    end
  end

  // Mode and filter values take effect at the start of a period
  always @(posedge clk)
  begin
    if (rst)
    begin
      mode_reg <= `MODE_RESONANT;
      duty_reg <= {WIDTH{1'b0}};
      fperiod_reg <= {WIDTH{1'b0}};
    end
    else if (clkEn && (periodStart || !run))
    begin
      mode_reg <= ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB]; // [R3]
      duty_reg <= filterDuty;
      fperiod_reg <= filterPeriod; // [R4]
    end
  end

  period_counter #(
    .WIDTH(WIDTH)
  ) counter (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .run(run),
    .periodLimit(period_limit_reg),
    .count_reg(count),
    .periodStart(periodStart)
  );

  // Arithmetic wraps modulo the counter width by design
  assign deadTime1 = ev3_reg - ev2_reg; // [R5]
  assign deadTime2 = ev1_reg + period_limit_reg - ev4_reg; // [R5]
  assign deadSum = {1'b0, deadTime1} + {1'b0, deadTime2};
  assign deadAvg = deadSum[WIDTH:1]; // [R6]
  assign dutyHalf = {1'b0, duty_reg[WIDTH-1:1]};
  assign periodHalf = {1'b0, period_limit_reg[WIDTH-1:1]};
  assign resOn = ev1_reg + duty_reg - deadAvg; // [R7]
  assign leadRise = ev1_reg - duty_reg + adjA_reg; // [R17]

  always @*
  begin
    aRise = {WIDTH{1'b0}};
    aFall = {WIDTH{1'b0}};
    bRise = {WIDTH{1'b0}};
    bFall = {WIDTH{1'b0}};
    adaptAt = {WIDTH{1'b0}};
    aActive = 1'b0;
    adaptActive = 1'b0;
    case (mode_reg) // [R3]
      `MODE_RESONANT:
      begin
        aActive = 1'b1;
        adaptActive = 1'b1;
        aRise = ev1_reg; // [R9]
        aFall = resOn; // [R7]
        bRise = resOn + deadTime1; // [R7]
        bFall = fperiod_reg - (period_limit_reg - ev4_reg); // [R8]
        if (ctrl_reg[`CTRL_ADAPT_SEL])
          adaptAt = ev1_reg + dutyHalf + adapt_reg;
        else
          adaptAt = ev1_reg + duty_reg + adapt_reg;
      end
      `MODE_TRIANGULAR:
      begin
        aActive = 1'b0; // [R11]
        adaptActive = 1'b0; // [R11]
        bRise = periodHalf - dutyHalf + adjA_reg; // [R10] [R12]
        bFall = periodHalf + dutyHalf + adjB_reg; // [R10] [R13]
      end
      `MODE_LEADING:
      begin
        aActive = 1'b1;
        adaptActive = 1'b1;
        aFall = ev1_reg; // [R16]
        aRise = leadRise; // [R17]
        bRise = ev4_reg; // [R20]
        bFall = leadRise - (ev2_reg - ev3_reg); // [R21]
        if (ctrl_reg[`CTRL_ADAPT_SEL])
          adaptAt = ev1_reg - dutyHalf + adapt_reg; // [R19]
        else
          adaptAt = ev1_reg - duty_reg + adapt_reg; // [R18]
      end
      default:
      begin
        aActive = 1'b0;
        adaptActive = 1'b0;
      end
    endcase
  end

  edge_toggle #(
    .WIDTH(WIDTH)
  ) primaryEdge (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .active(run && aActive),
    .count(count),
    .riseAt(aRise),
    .fallAt(aFall),
    .out_reg(primary_pulse_out)
  );

  edge_toggle #(
    .WIDTH(WIDTH)
  ) secondaryEdge (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .active(run),
    .count(count),
    .riseAt(bRise),
    .fallAt(bFall),
    .out_reg(secondary_pulse_out)
  );

  assign phaseAt = ctrl_reg[`CTRL_PHASE_SRC] ? duty_reg : phase_reg; // [R14]

  // Blanking windows open at begin, close at end; end wins a tie
  assign blankANext = (count == blkAEnd_reg) ? 1'b0 :
    ((count == blkABeg_reg) ? 1'b1 : blankA_reg); // [R15]
  assign blankBNext = (count == blkBEnd_reg) ? 1'b0 :
    ((count == blkBBeg_reg) ? 1'b1 : blankB_reg); // [R15]
  assign blankA = blankA_reg;
  assign blankB = blankB_reg;

  always @(posedge clk)
  begin
    if (rst)
    begin
      adaptTrig <= 1'b0;
      phaseTrig <= 1'b0;
      sampTrig1 <= 1'b0;
      sampTrig2 <= 1'b0;
      blankA_reg <= 1'b0;
      blankB_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      adaptTrig <= run && adaptActive && (count == adaptAt); // [R2]
      phaseTrig <= run && (count == phaseAt); // [R2] [R14]
      sampTrig1 <= run && (count == samp1_reg); // [R15]
      sampTrig2 <= run && (count == samp2_reg); // [R15]
      blankA_reg <= run && blankANext;
      blankB_reg <= run && blankBNext;
    end
  end
endmodule // pulse_edge_generator
`default_nettype wire

/* pulse_edge_consts.vh */
/*
  Shared constants for the pulse edge generator: register offsets,
  reset values and mode encodings. Included by the generator and the checker.
  Assumes a 16-bit register port with one word per offset.

//Contract
//R1 - Period counter counts zero to period_limit, restarts
//R2 - Signal toggles when counter equals its target
//R3 - Mode select picks resonant, triangular, leading equations
//R4 - Filter period must equal twice filter duty
//R5 - Dead times from event differences and period
//R6 - Average dead time is half their sum
//R7 - Resonant: duty minus average dead time, both outputs
//R8 - Resonant: secondary falls at filter period minus offset
//R9 - Resonant: only primary rising edge stays fixed
//R10 - Triangular pulse centred in the period
//R11 - Triangular: primary silent, no adaptive trigger
//R12 - Triangular rise: half period, minus half duty, plus A
//R13 - Triangular fall: half period, half duty, B added
//R14 - Phase trigger from register or filter duty
//R15 - Sample triggers and blanking from own registers
//R16 - Leading edge: primary falls at event one
//R17 - Leading: primary rises at event1, minus duty, plus A
//R18 - Leading: trigger A at event1, minus duty, offset
//R19 - Leading edge: trigger B uses half duty
//R20 - Leading edge: secondary rises at event four
//R21 - Leading: secondary falls dead time before primary
*/
`ifndef PULSE_EDGE_CONSTS_VH
`define PULSE_EDGE_CONSTS_VH

`define ADDR_CTRL 5'h00
`define ADDR_PERIOD 5'h01
`define ADDR_EVENT1 5'h02
`define ADDR_EVENT2 5'h03
`define ADDR_EVENT3 5'h04
`define ADDR_EVENT4 5'h05
`define ADDR_ADJ_A 5'h06
`define ADDR_ADJ_B 5'h07
`define ADDR_ADAPT 5'h08
`define ADDR_PHASE 5'h09
`define ADDR_SAMP1 5'h0A
`define ADDR_SAMP2 5'h0B
`define ADDR_BLKA_BEG 5'h0C
`define ADDR_BLKA_END 5'h0D
`define ADDR_BLKB_BEG 5'h0E
`define ADDR_BLKB_END 5'h0F
`define ADDR_STATUS 5'h10
`define ADDR_COUNT 5'h11

`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_PHASE_SRC 2
`define CTRL_ADAPT_SEL 3
`define CTRL_ENABLE 4

`define MODE_RESONANT 2'h0
`define MODE_TRIANGULAR 2'h1
`define MODE_LEADING 2'h2

`define PERIOD_RESET 16'h00FF
`define EVENT_RESET 16'h0000

`endif

/* period_counter.v */
/*
  Switching period counter: counts from zero to the period limit and
  flags the start of each period. Assumes a synchronous active-high
  reset and a clock enable that freezes the count.
*/
`timescale 1ns/1ps
`default_nettype none
module period_counter #(
  parameter WIDTH = 16
) (
  // Clock and control
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire run,
  // Period limit and state
  input wire [WIDTH-1:0] periodLimit,
  output reg [WIDTH-1:0] count_reg,
  output wire periodStart
);
  wire atLimit;
  reg [WIDTH-1:0] count_next;

  assign atLimit = (count_reg >= periodLimit);
  assign periodStart = run && (count_reg == {WIDTH{1'b0}});

  always @*
  begin
    if (!run)
      count_next = {WIDTH{1'b0}};
    else if (atLimit)
      count_next = {WIDTH{1'b0}}; // [R1]
    else
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1}; // [R1]
  end

  always @(posedge clk)
  begin
    if (rst)
      count_reg <= {WIDTH{1'b0}};
    else if (clkEn)
      count_reg <= count_next;
  end
endmodule // period_counter
`default_nettype wire

/* edge_toggle.v */
/*
  Match-driven output: sets on a rising-edge match, clears on a
  falling-edge match. Assumes targets stable for a whole period.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_toggle #(
  parameter WIDTH = 16
) (
  // Clock and control
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire active,
  // Counter and targets
  input wire [WIDTH-1:0] count,
  input wire [WIDTH-1:0] riseAt,
  input wire [WIDTH-1:0] fallAt,
  output reg out_reg
);
  reg out_next;

  // Fall wins a tie so a zero-width pulse stays low
  always @*
  begin
    if (!active)
      out_next = 1'b0;
    else if (count == fallAt)
      out_next = 1'b0; // [R2]
    else if (count == riseAt)
      out_next = 1'b1; // [R2]
    else
      out_next = out_reg;
  end

  always @(posedge clk)
  begin
    if (rst)
      out_reg <= 1'b0;
    else if (clkEn)
      out_reg <= out_next;
  end
endmodule // edge_toggle
`default_nettype wire

/* pulse_edge_asserts.sv */
/*
  Port-level checks for the pulse edge generator, bound to it.
  Assumes registers change only through the register port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pulse_edge_consts.vh"
module pulse_edge_checker #(
  parameter WIDTH = 16
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Register port and filter
  input wire logic [4:0] regAddr,
  input wire logic [WIDTH-1:0] regWdata,
  input wire logic regWr,
  input wire logic [WIDTH-1:0] regRdata,
  input wire logic [WIDTH-1:0] filterDuty,
  // Outputs
  input wire logic primary_pulse_out,
  input wire logic secondary_pulse_out,
  input wire logic adaptTrig,
  input wire logic phaseTrig,
  input wire logic sampTrig1,
  input wire logic sampTrig2,
  input wire logic blankA,
  input wire logic blankB
);
  logic [15:0] ctrlSh, perSh, adjSh, begSh, endSh, gap, hiA, hiP, quiet;
  wire [7:0] outs = {primary_pulse_out, secondary_pulse_out, adaptTrig,
    phaseTrig, sampTrig1, sampTrig2, blankA, blankB};
  // Mode and filter latch at period start, so wait two periods after writes
  wire settled = quiet > (perSh << 1) + 16'h0004;
  always @(posedge clk)
  begin
    if (rst)
    begin
      ctrlSh <= 16'h0000;
      perSh <= `PERIOD_RESET;
      adjSh <= 16'h0000;
      begSh <= 16'h0000;
      endSh <= 16'h0000;
      quiet <= 16'h0000;
    end
    else if (clkEn && regWr)
    begin
      quiet <= 16'h0000;
      case (regAddr)
        `ADDR_CTRL: ctrlSh <= regWdata;
        `ADDR_PERIOD: perSh <= regWdata;
        `ADDR_ADJ_A: adjSh <= regWdata;
        `ADDR_BLKA_BEG: begSh <= regWdata;
        `ADDR_BLKA_END: endSh <= regWdata;
        default: ;
      endcase
    end
    else if (!clkEn)
      quiet <= 16'h0000;
    else if (quiet != 16'hFFFF)
      quiet <= quiet + 16'h0001;
    gap <= (rst || sampTrig1) ? 16'h0001 : gap + 16'h0001;
    hiA <= blankA ? hiA + 16'h0001 : 16'h0000;
    hiP <= primary_pulse_out ? hiP + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_drop;
    phaseTrig ##1 !phaseTrig;
  endsequence
  a_reset_quiet: assert property ($fell(rst) && $past(clkEn) |->
    outs == 8'h00 && regRdata == 16'h0000) else $error("output after reset");
  a_freeze_hold: assert property (!clkEn |=>
    $stable(outs) && $stable(regRdata)) else $error("moved while frozen");
  a_adapt_pulse: assert property (adaptTrig && clkEn |=> !adaptTrig)
    else $error("adaptive trigger too long");
  a_phase_pulse: assert property ($rose(phaseTrig) && clkEn |-> s_drop)
    else $error("phase trigger too long");
  a_samp_period: assert property (sampTrig1 && settled |->
    gap == perSh + 16'h0001) else $error("period length wrong");
  a_tri_silent: assert property (ctrlSh[1:0] == `MODE_TRIANGULAR &&
    ctrlSh[`CTRL_ENABLE] && settled |-> !primary_pulse_out && !adaptTrig)
    else $error("primary active in triangular");
  a_blank_len: assert property ($fell(blankA) && settled |->
    hiA == endSh - begSh) else $error("blanking length wrong");
  a_lead_width: assert property ($fell(primary_pulse_out) && settled &&
    ctrlSh[1:0] == `MODE_LEADING |-> hiP == filterDuty - adjSh)
    else $error("leading on-time wrong");
endmodule // pulse_edge_checker
bind pulse_edge_generator pulse_edge_checker #(.WIDTH(WIDTH)) chk_inst (
  .clk, .rst, .clkEn, .regAddr, .regWdata, .regWr, .regRdata, .filterDuty,
  .primary_pulse_out, .secondary_pulse_out, .adaptTrig, .phaseTrig,
  .sampTrig1, .sampTrig2, .blankA, .blankB);
`default_nettype wire

/* filter_model.sv */
/*
  Compensator filter stand-in: duty follows a request after a lag and
  period is always twice duty. Assumes a consumer on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module filter_model #(
  parameter int LAG = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request and filter outputs
  input wire logic [15:0] dutyReq,
  output logic [15:0] filterDuty,
  output logic [15:0] filterPeriod
);
  int waitCnt;
  // The lag mimics a slow loop; the generator must latch at period start
  always @(posedge clk)
  begin
    if (rst)
    begin
      waitCnt <= 0;
      filterDuty <= 16'h0000;
    end
    else if (dutyReq === filterDuty)
      waitCnt <= 0;
    else if (waitCnt < LAG)
      waitCnt <= waitCnt + 1;
    else
      filterDuty <= dutyReq;
  end
  assign filterPeriod = filterDuty << 1;
endmodule // filter_model
`default_nettype wire

/* testbench.sv */
/*
  Self-checking bench: register port, edge positions in three modes,
  clock enable freeze. Assumes filter_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] L16 = 16'h0027, D = 16'h000E, AJA = 16'h0001,
    AJB = 16'h0002, OFS = 16'h0004, S2 = 16'h0009, BA0 = 16'h0004,
    BA1 = 16'h0008, BB0 = 16'h000A, BB1 = 16'h000C, NO = 16'hFFFF;
  logic clk, rst, clkEn, regWr, regRd;
  logic [4:0] regAddr;
  logic [15:0] regWdata, regRdata, dutyReq, filterDuty, filterPeriod;
  logic [15:0] v1, v2, e1, e2, e3, e4, av, pe;
  logic primary_pulse_out, secondary_pulse_out, adaptTrig, phaseTrig;
  logic sampTrig1, sampTrig2, blankA, blankB;
  logic [15:0] expR [7], expF [7];
  int err_count = 0;
  int n_compared = 0;
  wire [6:0] sig = {blankB, blankA, sampTrig2, phaseTrig, adaptTrig,
    secondary_pulse_out, primary_pulse_out};
  pulse_edge_generator pulse_edge_generator_inst (.clk, .rst, .clkEn,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .filterDuty,
    .filterPeriod, .primary_pulse_out, .secondary_pulse_out, .adaptTrig,
    .phaseTrig, .sampTrig1, .sampTrig2, .blankA, .blankB);
  filter_model #(.LAG(3)) filter_model_inst (.clk, .rst, .dutyReq,
    .filterDuty, .filterPeriod);
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1 d = regRdata;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'h1;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
  endtask
  // Fresh reset per mode so no output is left high by the previous mode
  task automatic setup(logic [15:0] c, logic [15:0] ph);
    logic [15:0] v [1:15];
    v = '{L16, e1, e2, e3, e4, AJA, AJB, OFS, ph, 16'h0000, S2, BA0, BA1,
      BB0, BB1};
    do_reset();
    for (int a = 1; a < 16; a++)
      wr(5'(a), v[a]);
    wr(5'h00, c);
  endtask
  task automatic setexp(logic [15:0] pr, pf, sr, sf, ad, ph);
    expR = '{pr, sr, ad, ph, S2, BA0, BB0};
    expF = '{pf, sf, (ad === NO) ? NO : ad + 16'h0001, ph + 16'h0001,
      S2 + 16'h0001, BA1, BB1};
  endtask
  // Edge positions are counted from the sample trigger 1 pulse at count 0
  task automatic run_mode(string m);
    logic [6:0] prv;
    logic [15:0] r [7], f [7];
    repeat (3 * (L16 + 1)) @(posedge clk);
    do
    begin
      @(posedge clk);
      #1;
    end
    while (sampTrig1 !== 1'h1);
    prv = sig;
    r = '{NO, NO, NO, NO, NO, NO, NO};
    f = r;
    for (int i = 1; i <= L16; i++)
    begin
      @(posedge clk);
      #1;
      for (int j = 0; j < 7; j++)
      begin
        if (!prv[j] && sig[j])
          r[j] = 16'(i);
        if (prv[j] && !sig[j])
          f[j] = 16'(i);
      end
      prv = sig;
    end
    for (int j = 0; j < 7; j++)
    begin
      check($sformatf("%s rise %0d", m, j), r[j], expR[j]);
      check($sformatf("%s fall %0d", m, j), f[j], expF[j]);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim();
  end
  initial
  begin
    rst = 1'h1;
    clkEn = 1'h1;
    regWr = 1'h0;
    regRd = 1'h0;
    regAddr = 5'h00;
    regWdata = 16'h0000;
    dutyReq = D;
    do_reset();
    rd(5'h01, v1);
    check("period reset", v1, 16'h00FF);
    wr(5'h1F, 16'h1234);
    rd(5'h1F, v1);
    check("unmapped", v1, 16'h0000);
    e1 = 16'h0002;
    e2 = 16'h0003;
    e3 = 16'h0005;
    e4 = 16'h0025;
    av = ((e3 - e2) + (e1 + L16 - e4)) >> 1;
    pe = e1 + D - av;
    setexp(e1, pe, pe + e3 - e2, (D << 1) - (L16 - e4), e1 + D + OFS,
      16'h001E);
    setup(16'h0010, 16'h001E);
    run_mode("resonant");
    setexp(NO, NO, (L16 >> 1) - (D >> 1) + AJA, (L16 >> 1) + (D >> 1) + AJB,
      NO, D);
    setup(16'h0015, 16'h0019);
    run_mode("triangular");
    e1 = 16'h001E;
    e3 = 16'h0003;
    e4 = 16'h0023;
    pe = e1 - D + AJA;
    setexp(pe, e1, e4, pe - (e2 - e3), e1 - (D >> 1) + OFS,
      16'h0019);
    setup(16'h001A, 16'h0019);
    run_mode("leading");
    setexp(pe, e1, e4, pe - (e2 - e3), e1 - D + OFS,
      16'h0019);
    setup(16'h0012, 16'h0019);
    run_mode("leading A");
    // Mode code 3 leaves both outputs and the adaptive trigger silent
    setexp(NO, NO, NO, NO, NO, 16'h0019);
    setup(16'h0013, 16'h0019);
    run_mode("off");
    rd(5'h11, v1);
    @(posedge clk);
    clkEn <= 1'h0;
    repeat (5) @(posedge clk);
    clkEn <= 1'h1;
    rd(5'h11, v2);
    check("count", v2, (v1 + 16'h0003) % (L16 + 16'h0001));
    end_sim();
  end
endmodule // testbench
`default_nettype wire
